// [include/bpc_pkg.sv]
`default_nettype none
package bpc_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] PACE_CFG_ADDR = 8'h1a * 8'h04; // Pace config, index 0x1a
  localparam logic [7:0] IMP_CFG_ADDR = 8'h80;          // Impedance frequency and drive
  localparam logic [7:0] GEN_CFG_ADDR = 8'h84;          // Master clock choice
  localparam logic [7:0] SYNC_ADDR = 8'h88;             // Resync command (write only)
  localparam logic [7:0] STAT_ADDR = 8'h8c;             // Status: frequency, discontinuity

  // Pace config field layout
  localparam int PACE_INV_BIT = 23;
  localparam int DERIV_DIS_BIT = 19;
  localparam int GAIN_LSB = 16;
  localparam int LOW_BW_BIT = 14;
  localparam int ANALOG_OUT_SEL_LSB = 12;
  localparam int POS_THR_LSB = 4;
  localparam int NEG_THR_LSB = 0;
  localparam logic [23:0] PACE_WR_MASK = 24'h8f70ff;    // Assigned bits only
  localparam logic [23:0] PACE_RESET = 24'h000055;      // Thresholds default 0101

  // Impedance config field layout: freq code [11:8], drive magnitude [6:4]
  localparam int FREQ_LSB = 8;
  localparam int MAG_LSB = 4;
  localparam logic [3:0] FREQ_RESET = 4'h8;
  localparam logic [2:0] MAG_RESET = 3'h0;

  // Master clock frequencies in Hz per select code
  localparam logic [17:0] FM_32768 = 18'd32768;
  localparam logic [17:0] FM_32000 = 18'd32000;
  localparam logic [17:0] FM_31968 = 18'd31968;

  // Offset frequencies used at codes 0001..0011, lowest step at codes 1010..1111
  localparam logic [17:0] OFF1_A = 18'd81920;
  localparam logic [17:0] OFF1_B = 18'd80000;
  localparam logic [17:0] OFF2_A = 18'd40960;
  localparam logic [17:0] OFF2_B = 18'd40000;
  localparam logic [17:0] OFF3_A = 18'd18204;
  localparam logic [17:0] OFF3_B = 18'd17780;
  localparam logic [17:0] LOW_A = 18'd128;
  localparam logic [17:0] LOW_B = 18'd125;

  // Resync sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_DONE = 3'b100
  } bpc_sync_e;

endpackage
`default_nettype wire

// [hw/bpc_freq.sv]
`timescale 1ns/100ps
`default_nettype none
module bpc_freq (
  input wire logic [1:0] msel,   // Master clock select
  input wire logic [3:0] fcode,  // Frequency select code
  output logic [17:0] freq_hz    // Modulation frequency in Hz
);
  logic [17:0] fm;    // Master clock in Hz
  logic alt_off;      // Offset table differs for the 32,000 Hz choices
  logic [17:0] low;   // Lowest frequency step

  ////////////////////////////////////////////////////////////////////////
  // Lookup purely combinational; bpc_top registers it once, so status lags by one cycle
  always_comb
  begin
    alt_off = (msel == 2'h1) || (msel == 2'h2);
    case (msel)
      2'h0: fm = bpc_pkg::FM_32768;
      2'h3: fm = bpc_pkg::FM_31968;
      default: fm = bpc_pkg::FM_32000;
    endcase
    low = (msel == 2'h0) ? bpc_pkg::LOW_A : bpc_pkg::LOW_B;
    case (fcode)
      4'h0: freq_hz = fm << 2;
      // Shifted frequencies reduce crosstalk into ECG and pace
      4'h1: freq_hz = alt_off ? bpc_pkg::OFF1_B : bpc_pkg::OFF1_A;
      4'h2: freq_hz = alt_off ? bpc_pkg::OFF2_B : bpc_pkg::OFF2_A;
      4'h3: freq_hz = alt_off ? bpc_pkg::OFF3_B : bpc_pkg::OFF3_A;
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9:
        // 31,968 Hz rounds to 500 and 250 at the two slowest steps
        freq_hz = (msel == 2'h3 && fcode[3]) ? ((fcode[0]) ? 18'd250 : 18'd500)
                  : (fm >> (fcode - 4'h2));
      default: freq_hz = low;
    endcase
  end
endmodule
`default_nettype wire

// [hw/bpc_top.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module bpc_top (
  input wire logic CLK,                 // 40 MHz clock
  input wire logic RST_B,               // Synchronous reset, active low
  input wire logic PSEL,                // APB select
  input wire logic PENABLE,             // APB access phase
  input wire logic PWRITE,              // APB direction
  input wire logic [7:0] PADDR,         // APB byte address
  input wire logic [31:0] PWDATA,       // APB write data
  output logic [31:0] PRDATA,           // APB read data
  output logic PREADY,                  // APB ready
  output logic PSLVERR,                 // APB error, unmapped address
  output logic PACE_INPUT_INVERT,       // Pace polarity
  output logic DERIVATIVE_DISABLE,      // Pace differentiator off
  output logic [2:0] PACE_GAIN_SEL,     // Pace gain
  output logic ANALOG_BUF_LOW_BW,       // Output buffer bandwidth limit
  output logic [1:0] ANALOG_OUT_SEL,    // Analog output source
  output logic [3:0] POS_DETECT_THRESHOLD, // Positive threshold
  output logic [3:0] NEG_DETECT_THRESHOLD, // Negative threshold
  output logic [3:0] BIOZ_MOD_FREQ_SEL, // Frequency code
  output logic [2:0] DRIVE_MAGNITUDE_SEL, // Drive magnitude
  output logic [17:0] MOD_FREQ_HZ,      // Resulting modulation frequency
  output logic RESYNC_PULSE,            // Restart shared-channel timing
  output logic STREAM_DISCONT           // Sticky: stream may be discontinuous
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [23:0] pace_q, pace_d;          // Pace config
  logic [3:0] freq_q, freq_d;           // Frequency code
  logic [2:0] mag_q, mag_d;             // Drive magnitude
  logic [1:0] msel_q, msel_d;           // Master clock select
  logic disc_q, disc_d;                 // Discontinuity flag
  logic ready_q;                        // One wait state for reads and writes
  logic err_q;                          // Error answer
  logic [31:0] rdata_q;                 // Read data
  logic [17:0] freq_hz_q;               // Registered frequency
  logic [17:0] freq_hz;                 // Lookup result
  bpc_pkg::bpc_sync_e st_q, st_d;       // Resync sequencer

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire access = PSEL && PENABLE && !ready_q;   // Answer on second access cycle
  wire wr = access && PWRITE;
  wire hit_pace = PADDR == bpc_pkg::PACE_CFG_ADDR;
  wire hit_imp = PADDR == bpc_pkg::IMP_CFG_ADDR;
  wire hit_gen = PADDR == bpc_pkg::GEN_CFG_ADDR;
  wire hit_sync = PADDR == bpc_pkg::SYNC_ADDR;
  wire hit_stat = PADDR == bpc_pkg::STAT_ADDR;
  wire mapped = hit_pace || hit_imp || hit_gen || hit_sync || hit_stat;
  // Unassigned bits are masked out of the write and so read zero
  wire [23:0] pace_wr = PWDATA[23:0] & bpc_pkg::PACE_WR_MASK;
  wire pace_chg = wr && hit_pace && (pace_wr != pace_q);
  wire imp_chg = wr && hit_imp &&
                 ((PWDATA[bpc_pkg::FREQ_LSB +: 4] != freq_q) ||
                  (PWDATA[bpc_pkg::MAG_LSB +: 3] != mag_q));
  wire sync_req = wr && hit_sync;
  // Drive magnitude is software's duty; the block keeps what is written
  wire [31:0] rd_mux = hit_pace ? {8'h00, pace_q} :
                       hit_imp ? {20'h00000, freq_q, 1'b0, mag_q, 4'h0} :
                       hit_gen ? {30'h00000000, msel_q} :
                       hit_stat ? {13'h0000, freq_hz_q, 1'b0} | {31'h00000000, disc_q} :
                       32'h00000000;

  bpc_freq u_freq (
    .msel(msel_q),
    .fcode(freq_q),
    .freq_hz(freq_hz)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb
  begin
    pace_d = (wr && hit_pace) ? pace_wr : pace_q;
    freq_d = (wr && hit_imp) ? PWDATA[bpc_pkg::FREQ_LSB +: 4] : freq_q;
    mag_d = (wr && hit_imp) ? PWDATA[bpc_pkg::MAG_LSB +: 3] : mag_q;
    msel_d = (wr && hit_gen) ? PWDATA[1:0] : msel_q;
    // A change sets the flag; it wins over a resync clearing it
    disc_d = (pace_chg || imp_chg) ? 1'b1 :
             (st_q == bpc_pkg::ST_DONE) ? 1'b0 : disc_q;
    case (st_q)
      bpc_pkg::ST_IDLE: st_d = sync_req ? bpc_pkg::ST_SYNC : bpc_pkg::ST_IDLE;
      bpc_pkg::ST_SYNC: st_d = bpc_pkg::ST_DONE;
      bpc_pkg::ST_DONE: st_d = bpc_pkg::ST_IDLE;
      default: st_d = bpc_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Config state
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      pace_q <= bpc_pkg::PACE_RESET;
      freq_q <= bpc_pkg::FREQ_RESET;
      mag_q <= bpc_pkg::MAG_RESET;
      msel_q <= 2'h0;
      disc_q <= 1'b0;
      st_q <= bpc_pkg::ST_IDLE;
    end
    else
    begin
      pace_q <= pace_d;
      freq_q <= freq_d;
      mag_q <= mag_d;
      msel_q <= msel_d;
      disc_q <= disc_d;
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer and registered outputs
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
      freq_hz_q <= 18'h00000;
      RESYNC_PULSE <= 1'b0;
    end
    else
    begin
      ready_q <= access;
      err_q <= access && !mapped;
      rdata_q <= (access && !PWRITE) ? rd_mux : rdata_q;
      freq_hz_q <= freq_hz;
      RESYNC_PULSE <= st_q == bpc_pkg::ST_SYNC;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field outputs come straight from the config flops
  assign PRDATA = rdata_q;
  assign PREADY = ready_q;
  assign PSLVERR = err_q;
  assign PACE_INPUT_INVERT = pace_q[bpc_pkg::PACE_INV_BIT];
  assign DERIVATIVE_DISABLE = pace_q[bpc_pkg::DERIV_DIS_BIT];
  assign PACE_GAIN_SEL = pace_q[bpc_pkg::GAIN_LSB +: 3];
  assign ANALOG_BUF_LOW_BW = pace_q[bpc_pkg::LOW_BW_BIT];
  assign ANALOG_OUT_SEL = pace_q[bpc_pkg::ANALOG_OUT_SEL_LSB +: 2];
  assign POS_DETECT_THRESHOLD = pace_q[bpc_pkg::POS_THR_LSB +: 4];
  assign NEG_DETECT_THRESHOLD = pace_q[bpc_pkg::NEG_THR_LSB +: 4];
  assign BIOZ_MOD_FREQ_SEL = freq_q;
  assign DRIVE_MAGNITUDE_SEL = mag_q;
  assign MOD_FREQ_HZ = freq_hz_q;
  assign STREAM_DISCONT = disc_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_unused_zero;
    @(posedge CLK) disable iff (!RST_B) (pace_q & ~bpc_pkg::PACE_WR_MASK) == 24'h000000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unassigned pace bits set");

  property p_pace_write;
    @(posedge CLK) disable iff (!RST_B) (wr && hit_pace) |=> pace_q == $past(pace_wr);
  endproperty
  a_pace_write: assert property (p_pace_write) else $error("pace write lost");

  property p_code0;
    @(posedge CLK) disable iff (!RST_B) (freq_q == 4'h0 && msel_q == 2'h0)
      |=> MOD_FREQ_HZ == 18'd131072;
  endproperty
  a_code0: assert property (p_code0) else $error("code 0 frequency wrong");

  property p_low;
    @(posedge CLK) disable iff (!RST_B) (freq_q[3] && (freq_q[2] || freq_q[1])
      && msel_q == 2'h0) |=> MOD_FREQ_HZ == 18'd128;
  endproperty
  a_low: assert property (p_low) else $error("lowest frequency wrong");

  property p_offset;
    @(posedge CLK) disable iff (!RST_B) (freq_q == 4'h3 && msel_q == 2'h0)
      |=> MOD_FREQ_HZ == 18'd18204;
  endproperty
  a_offset: assert property (p_offset) else $error("offset frequency wrong");

  property p_disc;
    @(posedge CLK) disable iff (!RST_B) (pace_chg || imp_chg) |=> STREAM_DISCONT;
  endproperty
  a_disc: assert property (p_disc) else $error("change not flagged");

  property p_sync;
    @(posedge CLK) disable iff (!RST_B) (sync_req && st_q == bpc_pkg::ST_IDLE)
      |=> ##1 RESYNC_PULSE ##1 !RESYNC_PULSE;
  endproperty
  a_sync: assert property (p_sync) else $error("resync pulse wrong");

  property p_reset_thr;
    @(posedge CLK) !RST_B |=> POS_DETECT_THRESHOLD == 4'h5 && NEG_DETECT_THRESHOLD == 4'h5;
  endproperty
  a_reset_thr: assert property (p_reset_thr) else $error("threshold default wrong");

  // Fields are held against the bus bits, not the flop they come from
  property p_gain;
    @(posedge CLK) disable iff (!RST_B) (wr && hit_pace)
      |=> PACE_GAIN_SEL == $past(PWDATA[18:16])
      && DERIVATIVE_DISABLE == $past(PWDATA[19])
      && ANALOG_OUT_SEL == $past(PWDATA[13:12]);
  endproperty
  a_gain: assert property (p_gain) else $error("field mapping wrong");
endmodule
`default_nettype wire

// [tb/bioz_mod_and_pace_config_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module bioz_mod_and_pace_config_bench;
  logic clk = 1'b0; // Bench clock
  logic rst_b = 1'b0; // Reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h00000000; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready, pslverr, inv, ddis, lbw, rsp, disc; // Single-bit outputs
  logic [2:0] gain, mag; // Gain and magnitude
  logic [1:0] analog_out_sel; // Output source
  logic [3:0] pthr, nthr, fsel; // Thresholds and frequency code
  logic [17:0] fhz; // Modulation frequency
  int failures = 0; // Mismatch count
  int cmp_count = 0; // Comparison count
  logic [31:0] rd; // Last read data
  logic er; // Last error flag
  logic [2:0] mv; // Largest magnitude allowed at the code under test
  // Expected frequencies per master select, last slot for 101x and 11xx
  logic [17:0] f0 [11] = '{131072, 81920, 40960, 18204, 8192, 4096, 2048, 1024, 512, 256, 128};
  logic [17:0] f1 [11] = '{128000, 80000, 40000, 17780, 8000, 4000, 2000, 1000, 500, 250, 125};
  logic [17:0] f3 [11] = '{127872, 81920, 40960, 18204, 7992, 3996, 1998, 999, 500, 250, 125};
  logic [23:0] pw [3] = '{24'hffffff, 24'h735a3c, 24'h842000}; // Pace write patterns
  logic [23:0] pe [3] = '{24'h8f70ff, 24'h03503c, 24'h842000}; // Patterns after masking

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #12.5 clk = ~clk;

  bpc_top u_bpc_top (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PACE_INPUT_INVERT(inv), .DERIVATIVE_DISABLE(ddis),
    .PACE_GAIN_SEL(gain), .ANALOG_BUF_LOW_BW(lbw), .ANALOG_OUT_SEL(analog_out_sel),
    .POS_DETECT_THRESHOLD(pthr), .NEG_DETECT_THRESHOLD(nthr), .BIOZ_MOD_FREQ_SEL(fsel),
    .DRIVE_MAGNITUDE_SEL(mag), .MOD_FREQ_HZ(fhz), .RESYNC_PULSE(rsp), .STREAM_DISCONT(disc));

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // Data and error taken at the ready edge only
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      $display("MISMATCH at %0t: no ready", $time);
    end
  endtask

  // Value comparison; case equality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need well under 2000 cycles
  initial
  begin
    #(25 * 5000);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, bpc_pkg::PACE_CFG_ADDR, 32'h0);
    chk(rd, 32'h00000055);
    chk({er, disc, fhz}, {2'b00, 18'd512});
    $display("Test reset done");
    // No filter choice lives in this block, so pace use needs no filter write
    // Pace fields: every assigned bit, unassigned bits dropped
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, bpc_pkg::PACE_CFG_ADDR, {8'hff, pw[i]});
      apb(1'b0, bpc_pkg::PACE_CFG_ADDR, 32'h0);
      chk(rd, {8'h00, pe[i]});
      chk({inv, ddis}, {pe[i][23], pe[i][19]});
      chk(gain, pe[i][18:16]);
      chk({lbw, analog_out_sel}, pe[i][14:12]);
      chk({pthr, nthr}, pe[i][7:0]);
    end
    $display("Test pace fields done");
    // Change was written, so the stream flag is up; resync clears it
    chk(disc, 1'b1);
    apb(1'b1, bpc_pkg::SYNC_ADDR, 32'h1);
    // Pulse rises at the edge that completes the write; flag clears one edge later
    #1 chk({rsp, disc}, 2'b11);
    @(posedge clk);
    #1 chk({rsp, disc}, 2'b00);
    @(posedge clk);
    #1 chk(rsp, 1'b0);
    apb(1'b1, bpc_pkg::PACE_CFG_ADDR, {8'h00, pe[2]});
    repeat (2) @(posedge clk);
    #1 chk(disc, 1'b0);
    $display("Test resync done");
    // Every master select against every frequency code
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, bpc_pkg::GEN_CFG_ADDR, m);
      for (int c = 0; c < 16; c++)
      begin
        // Software keeps to the magnitudes allowed at each code
        mv = (c < 6) ? 3'h3 : (c == 6) ? 3'h2 : 3'h1;
        apb(1'b1, bpc_pkg::IMP_CFG_ADDR, {20'h0, c[3:0], 1'b0, mv, 4'h0});
        repeat (3) @(posedge clk);
        #1 chk({fsel, mag}, {c[3:0], mv});
        if (m == 0)
          chk(fhz, f0[c > 9 ? 10 : c]);
        else if (m == 3)
          chk(fhz, f3[c > 9 ? 10 : c]);
        else
          chk(fhz, f1[c > 9 ? 10 : c]);
      end
    end
    chk(disc, 1'b1);
    // Read back the impedance, clock and status words
    apb(1'b0, bpc_pkg::IMP_CFG_ADDR, 32'h0);
    chk(rd, {20'h0, 4'hf, 1'b0, 3'h1, 4'h0});
    apb(1'b0, bpc_pkg::GEN_CFG_ADDR, 32'h0);
    chk(rd, 32'h00000003);
    apb(1'b0, bpc_pkg::STAT_ADDR, 32'h0);
    chk(rd, {13'h0, 18'd125, 1'b1});
    $display("Test frequency table done");
    // Unmapped address is refused
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("Test unmapped done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
